/* File: logic/ata_regs_pkg.sv */
// Task-file constants for the drive/head and status registers
package ata_regs_pkg;
  localparam logic [2:0] DRIVE_HEAD_OFS = 3'h6;
  localparam logic [2:0] STATUS_OFS     = 3'h7;
  localparam int         HEAD_W         = 4;
  localparam int         DH_LBA_BIT     = 6;
  localparam int         DH_DEV_BIT     = 4;
  localparam int         ST_BUSY_BIT    = 7;
  localparam int         ST_READY_BIT   = 6;
  localparam int         ST_FAULT_BIT   = 5;
  localparam int         ST_SEEK_BIT    = 4;
  localparam int         ST_DRQ_BIT     = 3;
  localparam int         ST_ERR_BIT     = 0;
  localparam logic [7:0] DRIVE_HEAD_RST = 8'hA0;
  localparam logic [7:0] STATUS_UNSEL   = 8'h00;
  localparam logic [7:0] STATUS_BUSY    = 8'h80;
  typedef logic [HEAD_W-1:0] head_t;
endpackage

/* File: logic/ata_drive_head_status.sv */
// Drive/head and status task-file registers on the host pins
`timescale 1ns/10ps
// Summary of operation
// - Drive/head value selects drive and head
// - Head field follows head across tracks
// - Bit 6 chooses CYLINDER_HEAD_SECTOR_MODE or LBA
// - Bit 4 picks first or second drive
// - Single drive, select one: status reads 00h
// - CYLINDER_HEAD_SECTOR_MODE: bits 3..0 are head number
// - LBA: bits 3..0 are address 27..24
// - Status updates on completion and error
// - Busy set makes other status bits invalid
// - Busy blocks other task-file register access
// - Busy from reset, soft reset, command write
// - Status read acknowledges pending interrupt
// - Not ready refuses read, write, seek
// - Not ready mid-command aborts, ready held low
// - Fault sets fault, error, refuses media commands
// - Seek complete set at end, cleared at start
// - Data request while sector needs transfer
// - Error flags failed command, next clears
module ata_drive_head_status
  import ata_regs_pkg::*;
(
  input  wire logic               core_clk,
  input  wire logic               sys_rst,
  input  wire logic               cs0_n,
  input  wire logic [2:0]         da,
  input  wire logic               host_rd_n,
  input  wire logic               host_wr_n,
  input  wire logic [7:0]         hd_i,
  output logic [7:0]              hd_o,
  output logic                    hd_oe,
  input  wire logic               two_drive_cfg,
  input  wire logic               drive_id,
  input  wire logic               soft_reset_bit,
  input  wire logic               cmd_start,
  input  wire logic               cmd_media,
  input  wire logic               cmd_rw,
  input  wire logic               cmd_seek,
  input  wire logic               cmd_done,
  input  wire logic               cmd_fail,
  input  wire logic               seek_done,
  input  wire logic               seek_fail,
  input  wire logic               fault_evt,
  input  wire logic               drive_ready_in,
  input  wire logic               sector_req,
  input  wire logic               head_update,
  input  wire ata_regs_pkg::head_t head_new,
  input  wire logic               intrq_pending,
  output logic                    intrq_ack,
  output logic                    cmd_abort,
  output logic                    cmd_accepted,
  output logic                    drive_selected,
  output logic                    lba_mode,
  output ata_regs_pkg::head_t     head_select_field,
  output logic [3:0]              lba_high,
  output logic                    rw_allowed,
  output logic                    taskfile_blocked
);
  import ata_regs_pkg::*;

  function automatic logic addr_hit(input logic [2:0] a, input logic [2:0] ofs);
    addr_hit = (a == ofs);
  endfunction

  // Host pins cross into core_clk; third stage only for edge detection
  logic [2:0] cs_s_q, cs_s_d, rd_s_q, rd_s_d, wr_s_q, wr_s_d;
  logic [2:0] da1_q, da1_d, da2_q, da2_d;
  logic [7:0] dat1_q, dat1_d, dat2_q, dat2_d;

  logic [7:0] dh_q, dh_d, rdata_q, rdata_d;
  logic       busy_q, busy_d, ready_q, ready_d, hold_q, hold_d;
  logic       fault_q, fault_d, seek_q, seek_d, drq_q, drq_d, err_q, err_d;
  logic       active_q, active_d, abort_q, abort_d, ack_q, ack_d, acc_q, acc_d;
  logic       oe_q, oe_d;

  logic       sel_now, rd_act, rd_edge, wr_edge, hit_dh, hit_st, dev_bit;
  logic       refuse, not_ready_evt, fault_hit, st_rd_edge, dh_wr_ok;
  logic [7:0] status_val;

  always_comb begin
    cs_s_d = {cs_s_q[1:0], cs0_n};
    rd_s_d = {rd_s_q[1:0], host_rd_n};
    wr_s_d = {wr_s_q[1:0], host_wr_n};
    da1_d  = da;
    da2_d  = da1_q;
    dat1_d = hd_i;
    dat2_d = dat1_q;

    dev_bit = dh_q[DH_DEV_BIT];
    // Single drive answers only to drive select 0
    sel_now = two_drive_cfg ? (dev_bit == drive_id) : !dev_bit;
    hit_dh  = !cs_s_q[1] && addr_hit(da2_q, DRIVE_HEAD_OFS);
    hit_st  = !cs_s_q[1] && addr_hit(da2_q, STATUS_OFS);
    rd_act  = !rd_s_q[1];
    rd_edge = !rd_s_q[1] && rd_s_q[2];
    wr_edge = !wr_s_q[1] && wr_s_q[2];
    st_rd_edge = rd_edge && hit_st && sel_now;
    // Drive/head is shared by both drives, but host writes to it are ignored while busy
    dh_wr_ok = wr_edge && hit_dh && !busy_q;

    // Busy hides every other bit so a stale flag is never reported
    if (busy_q) begin
      status_val = STATUS_BUSY;
    end else begin
      status_val = 8'h00;
      status_val[ST_READY_BIT] = ready_q;
      status_val[ST_FAULT_BIT] = fault_q;
      status_val[ST_SEEK_BIT]  = seek_q;
      status_val[ST_DRQ_BIT]   = drq_q;
      status_val[ST_ERR_BIT]   = err_q;
    end

    refuse        = cmd_start && cmd_media && !(ready_q && !fault_q);
    not_ready_evt = active_q && !drive_ready_in && !hold_q;
    fault_hit     = fault_evt && active_q && cmd_rw;

    // Hardware head updates override the stored field mid-transfer
    dh_d = dh_q;
    if (dh_wr_ok) begin
      dh_d = dat2_q;
    end
    if (head_update) begin
      dh_d[HEAD_W-1:0] = head_new;
    end

    acc_d    = cmd_start && !refuse;
    active_d = active_q;
    if (cmd_done) begin
      active_d = 1'b0;
    end
    if (acc_d) begin
      active_d = 1'b1;
    end

    busy_d = busy_q;
    if (cmd_done) begin
      busy_d = 1'b0;
    end
    if (soft_reset_bit || acc_d) begin
      busy_d = 1'b1;
    end

    hold_d = hold_q;
    if (acc_d) begin
      hold_d = 1'b0;
    end
    if (not_ready_evt) begin
      hold_d = 1'b1;
    end
    ready_d = hold_d ? 1'b0 : drive_ready_in;

    // Fault latches until hardware reset; readiness does not undo it
    fault_d = fault_q || fault_hit;

    seek_d = seek_q;
    if (acc_d && cmd_seek) begin
      seek_d = 1'b0;
    end
    if (seek_done && !seek_fail) begin
      seek_d = 1'b1;
    end

    // Request outlives busy, else status would always mask it
    drq_d = sector_req && cmd_rw && (active_q || drq_q);

    // Event in the same cycle as the next command wins
    err_d = err_q;
    if (acc_d) begin
      err_d = 1'b0;
    end
    if (cmd_fail || refuse || not_ready_evt || fault_hit || (seek_fail && active_q)) begin
      err_d = 1'b1;
    end

    abort_d = refuse || not_ready_evt || fault_hit || (seek_fail && active_q);
    ack_d   = st_rd_edge && intrq_pending;

    rdata_d = rdata_q;
    oe_d    = 1'b0;
    if (rd_act && hit_st) begin
      if (sel_now) begin
        rdata_d = status_val;
        oe_d    = 1'b1;
      end else if (!two_drive_cfg) begin
        rdata_d = STATUS_UNSEL;
        oe_d    = 1'b1;
      end
    end else if (rd_act && hit_dh && sel_now && !busy_q) begin
      rdata_d = dh_q;
      oe_d    = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cs_s_q   <= 3'h7;
      rd_s_q   <= 3'h7;
      wr_s_q   <= 3'h7;
      da1_q    <= 3'h0;
      da2_q    <= 3'h0;
      dat1_q   <= 8'h00;
      dat2_q   <= 8'h00;
      dh_q     <= DRIVE_HEAD_RST;
      rdata_q  <= 8'h00;
      oe_q     <= 1'b0;
      busy_q   <= 1'b1;
      ready_q  <= 1'b0;
      hold_q   <= 1'b0;
      fault_q  <= 1'b0;
      seek_q   <= 1'b0;
      drq_q    <= 1'b0;
      err_q    <= 1'b0;
      active_q <= 1'b0;
      abort_q  <= 1'b0;
      ack_q    <= 1'b0;
      acc_q    <= 1'b0;
    end else begin
      cs_s_q   <= cs_s_d;
      rd_s_q   <= rd_s_d;
      wr_s_q   <= wr_s_d;
      da1_q    <= da1_d;
      da2_q    <= da2_d;
      dat1_q   <= dat1_d;
      dat2_q   <= dat2_d;
      dh_q     <= dh_d;
      rdata_q  <= rdata_d;
      oe_q     <= oe_d;
      busy_q   <= busy_d;
      ready_q  <= ready_d;
      hold_q   <= hold_d;
      fault_q  <= fault_d;
      seek_q   <= seek_d;
      drq_q    <= drq_d;
      err_q    <= err_d;
      active_q <= active_d;
      abort_q  <= abort_d;
      ack_q    <= ack_d;
      acc_q    <= acc_d;
    end
  end

  assign hd_o              = rdata_q;
  assign hd_oe             = oe_q && rd_act;
  assign intrq_ack         = ack_q;
  assign cmd_abort         = abort_q;
  assign cmd_accepted      = acc_q;
  assign drive_selected    = sel_now;
  assign lba_mode          = dh_q[DH_LBA_BIT];
  assign head_select_field = dh_q[HEAD_W-1:0];
  assign lba_high          = dh_q[DH_LBA_BIT] ? dh_q[HEAD_W-1:0] : 4'h0;
  assign rw_allowed        = ready_q && !fault_q;
  assign taskfile_blocked  = busy_q;

  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  a_busy_on_start: assert property (cmd_start && !refuse |=> busy_q)
    else $error("busy not set by accepted command");
  a_soft_reset_busy: assert property (soft_reset_bit |=> busy_q [*2])
    else $error("busy not held under soft reset");
  a_busy_masks_bits: assert property (busy_q |-> status_val == STATUS_BUSY)
    else $error("status bits visible while busy");
  a_reserved_zero: assert property (status_val[2:1] == 2'b00)
    else $error("reserved status bits set");
  a_unsel_zero: assert property (rd_act && hit_st && !two_drive_cfg && dev_bit
      |=> hd_o == STATUS_UNSEL && oe_q)
    else $error("unselected single drive not returning zero");
  a_ack_on_read: assert property (st_rd_edge && intrq_pending |=> intrq_ack)
    else $error("status read did not acknowledge interrupt");
  a_dh_write_blocked: assert property (wr_edge && hit_dh && busy_q && !head_update
      |=> $stable(dh_q))
    else $error("drive/head changed while busy");
  a_notready_hold: assert property (hold_q && !cmd_start |=> !ready_q)
    else $error("ready rose before next command");
  a_fault_err: assert property (fault_evt && active_q && cmd_rw
      |=> fault_q && err_q && !rw_allowed)
    else $error("fault did not set fault and error");
  a_seek_clear: assert property (cmd_start && !refuse && cmd_seek && !seek_done
      |=> !seek_q)
    else $error("seek flag not cleared at seek start");
  a_refuse_abort: assert property (cmd_start && cmd_media && !rw_allowed
      |=> cmd_abort && !cmd_accepted ##1 !cmd_abort || cmd_start)
    else $error("media command not refused");
  a_head_track: assert property (head_update |=> head_select_field == $past(head_new))
    else $error("head field not updated");
  a_drq_request: assert property (sector_req && active_q && cmd_rw |=> drq_q)
    else $error("data request not raised");
  a_dh_read_blocked: assert property (rd_act && hit_dh && busy_q |=> !oe_q)
    else $error("drive/head driven while busy");
  a_err_on_fail: assert property (cmd_fail |=> err_q)
    else $error("error flag not set on failure");
  a_lba_high_zero: assert property (!lba_mode |-> lba_high == 4'h0)
    else $error("upper address bits shown in head mode");
  a_busy_until_done: assert property (busy_q && !cmd_done |=> busy_q)
    else $error("busy dropped before completion");
  a_seek_set: assert property (seek_done && !seek_fail |=> seek_q)
    else $error("seek flag not set at seek end");
  a_ack_needs_pend: assert property (!intrq_pending |=> !intrq_ack)
    else $error("acknowledge without pending interrupt");
endmodule // ata_drive_head_status

/* File: tb/host_model.sv */
// Host-side pin model that runs task-file read and write cycles
`timescale 1ns/10ps
module host_model (
  input  wire logic       core_clk,
  output logic            cs0_n,
  output logic [2:0]      da,
  output logic            host_rd_n,
  output logic            host_wr_n,
  output logic [7:0]      hd_i,
  input  wire logic [7:0] hd_o,
  input  wire logic       hd_oe
);
  initial begin
    cs0_n = 1'b1;
    da = 3'h0;
    host_rd_n = 1'b1;
    host_wr_n = 1'b1;
    hd_i = 8'h00;
  end
  // Strobe held 5 cycles; data kept 2 more so the synced strobe still sees it
  task automatic write_reg(input logic [2:0] a, input logic [7:0] d);
    @(negedge core_clk);
    cs0_n = 1'b0;
    da = a;
    hd_i = d;
    host_wr_n = 1'b0;
    repeat (5) @(negedge core_clk);
    host_wr_n = 1'b1;
    repeat (2) @(negedge core_clk);
    cs0_n = 1'b1;
    hd_i = ~d;
    repeat (3) @(negedge core_clk);
  endtask
  // Only the two owned registers are touched, so busy never guards others
  task automatic read_reg(input logic [2:0] a, output logic [7:0] d, output logic oe);
    @(negedge core_clk);
    cs0_n = 1'b0;
    da = a;
    host_rd_n = 1'b0;
    repeat (4) @(negedge core_clk);
    d = hd_o;
    oe = hd_oe;
    host_rd_n = 1'b1;
    repeat (4) @(negedge core_clk);
    cs0_n = 1'b1;
  endtask
endmodule // host_model

/* File: tb/tb.sv */
// Self-checking bench for the drive/head and status registers
`timescale 1ns/10ps
module tb;
  import ata_regs_pkg::*;
  logic core_clk, sys_rst, cs0_n, host_rd_n, host_wr_n, hd_oe, two_drive_cfg, drive_id;
  logic soft_reset_bit, cmd_start, cmd_media, cmd_rw, cmd_seek, cmd_done, cmd_fail;
  logic seek_done, seek_fail, fault_evt, drive_ready_in, sector_req, head_update;
  logic intrq_pending, intrq_ack, cmd_abort, cmd_accepted, drive_selected, lba_mode;
  logic rw_allowed, taskfile_blocked;
  logic [2:0] da;
  logic [7:0] hd_i, hd_o;
  logic [3:0] lba_high;
  head_t      head_new, head_select_field;
  int         fails, compares, aborts, accepts, acks;
  ata_drive_head_status ata_drive_head_status_inst (
    .core_clk(core_clk), .sys_rst(sys_rst), .cs0_n(cs0_n), .da(da), .host_rd_n(host_rd_n),
    .host_wr_n(host_wr_n), .hd_i(hd_i), .hd_o(hd_o), .hd_oe(hd_oe),
    .two_drive_cfg(two_drive_cfg), .drive_id(drive_id), .soft_reset_bit(soft_reset_bit),
    .cmd_start(cmd_start), .cmd_media(cmd_media), .cmd_rw(cmd_rw), .cmd_seek(cmd_seek),
    .cmd_done(cmd_done), .cmd_fail(cmd_fail), .seek_done(seek_done), .seek_fail(seek_fail),
    .fault_evt(fault_evt), .drive_ready_in(drive_ready_in), .sector_req(sector_req),
    .head_update(head_update), .head_new(head_new), .intrq_pending(intrq_pending),
    .intrq_ack(intrq_ack), .cmd_abort(cmd_abort), .cmd_accepted(cmd_accepted),
    .drive_selected(drive_selected), .lba_mode(lba_mode),
    .head_select_field(head_select_field), .lba_high(lba_high), .rw_allowed(rw_allowed),
    .taskfile_blocked(taskfile_blocked));
  host_model host_model_inst (
    .core_clk(core_clk), .cs0_n(cs0_n), .da(da), .host_rd_n(host_rd_n),
    .host_wr_n(host_wr_n), .hd_i(hd_i), .hd_o(hd_o), .hd_oe(hd_oe));
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    aborts += (cmd_abort === 1'b1);
    accepts += (cmd_accepted === 1'b1);
    acks += (intrq_ack === 1'b1);
  end
  task automatic final_report;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Masked compare, since status bits other than busy may lag their inputs
  task automatic rd(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e,
                    input logic oe_e);
    logic [7:0] d;
    logic       oe;
    host_model_inst.read_reg(a, d, oe);
    chk({7'h00, oe}, {7'h00, oe_e});
    if (oe_e)
      chk(d & m, e);
  endtask
  task automatic cmd(input logic media);
    cmd_media = media;
    cmd_start = 1'b1;
    @(negedge core_clk);
    cmd_start = 1'b0;
    repeat (3) @(negedge core_clk);
  endtask
  task automatic done;
    cmd_done = 1'b1;
    @(negedge core_clk);
    cmd_done = 1'b0;
    repeat (3) @(negedge core_clk);
  endtask
  initial begin
    {two_drive_cfg, drive_id, soft_reset_bit, cmd_start, cmd_media, cmd_seek} = 6'h00;
    {cmd_done, cmd_fail, seek_done, seek_fail, fault_evt, sector_req} = 6'h00;
    {head_update, intrq_pending, head_new, fails, compares} = 0;
    {aborts, accepts, acks} = 0;
    cmd_rw = 1'b1;
    drive_ready_in = 1'b1;
    sys_rst = 1'b1;
    repeat (3) @(negedge core_clk);
    sys_rst = 1'b0;
    repeat (3) @(negedge core_clk);
    chk({7'h00, taskfile_blocked}, 8'h01);
    rd(STATUS_OFS, 8'hFF, STATUS_BUSY, 1'b1);
    rd(DRIVE_HEAD_OFS, 8'hFF, 8'h00, 1'b0);
    host_model_inst.write_reg(DRIVE_HEAD_OFS, 8'hE5);
    done();
    chk({7'h00, taskfile_blocked}, 8'h00);
    rd(DRIVE_HEAD_OFS, 8'hFF, DRIVE_HEAD_RST, 1'b1);
    rd(STATUS_OFS, 8'hEF, 8'h40, 1'b1);
    host_model_inst.write_reg(DRIVE_HEAD_OFS, 8'hE5);
    rd(DRIVE_HEAD_OFS, 8'hFF, 8'hE5, 1'b1);
    chk({2'b00, lba_mode, drive_selected, head_select_field}, 8'h35);
    chk({4'h0, lba_high}, 8'h05);
    host_model_inst.write_reg(DRIVE_HEAD_OFS, 8'hA3);
    chk({3'h0, lba_mode, head_select_field}, 8'h03);
    chk({4'h0, lba_high}, 8'h00);
    host_model_inst.write_reg(DRIVE_HEAD_OFS, 8'hB3);
    rd(STATUS_OFS, 8'hFF, STATUS_UNSEL, 1'b1);
    two_drive_cfg = 1'b1;
    drive_id = 1'b1;
    @(negedge core_clk);
    chk({7'h00, drive_selected}, 8'h01);
    host_model_inst.write_reg(DRIVE_HEAD_OFS, 8'hA3);
    rd(STATUS_OFS, 8'hFF, 8'h00, 1'b0);
    drive_id = 1'b0;
    intrq_pending = 1'b1;
    cmd_seek = 1'b1;
    cmd(1'b1);
    rd(STATUS_OFS, 8'hFF, STATUS_BUSY, 1'b1);
    intrq_pending = 1'b0;
    {head_update, head_new, seek_done, sector_req} = 7'h53;
    @(negedge core_clk);
    {head_update, seek_done} = 2'b00;
    done();
    chk({acks[3:0], head_select_field}, 8'h14);
    rd(STATUS_OFS, 8'hFF, 8'h58, 1'b1);
    sector_req = 1'b0;
    cmd(1'b1);
    done();
    rd(STATUS_OFS, 8'hFF, 8'h40, 1'b1);
    cmd(1'b1);
    drive_ready_in = 1'b0;
    repeat (3) @(negedge core_clk);
    done();
    rd(STATUS_OFS, 8'hE1, 8'h01, 1'b1);
    cmd(1'b1);
    drive_ready_in = 1'b1;
    chk({aborts[3:0], accepts[3:0]}, 8'h23);
    cmd(1'b0);
    done();
    rd(STATUS_OFS, 8'hE1, 8'h40, 1'b1);
    cmd(1'b0);
    cmd_fail = 1'b1;
    @(negedge core_clk);
    cmd_fail = 1'b0;
    done();
    rd(STATUS_OFS, 8'h81, 8'h01, 1'b1);
    cmd(1'b1);
    fault_evt = 1'b1;
    @(negedge core_clk);
    fault_evt = 1'b0;
    done();
    rd(STATUS_OFS, 8'hA1, 8'h21, 1'b1);
    cmd(1'b1);
    chk({7'h00, rw_allowed}, 8'h00);
    chk({aborts[3:0], accepts[3:0]}, 8'h46);
    soft_reset_bit = 1'b1;
    @(negedge core_clk);
    soft_reset_bit = 1'b0;
    rd(STATUS_OFS, 8'hFF, STATUS_BUSY, 1'b1);
    final_report();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    final_report();
  end
endmodule // tb
